//--- hdl/smm_pkg.sv
// Summary of operation
// - Config 94h bit 3 set keeps SMM space out of the CPU cache.
// - Config 18h bit 3 governs L2 caching of the whole 0A0000h-0FFFFFh shadow region.
// - 18h bits 3:2 at 10 with 94h bit 3 set: SMM uncached, shadow L1-cached.
// - Config 94h bit 2 enables holding the address-20 mask high during SMM.
// - Forced gate value is OR of inverted SMM level, keyboard and emulated gates.
// - SMM entry sends set-gate code on the link, exit sends reset-gate code.
// - No gate codes are sent when the internal gate is already high.
// - Gate forcing is never offered for strobe-style SMM CPUs.
// - Port 26 is the second index port and port 27 its data port.
// - Second window has its own index register and accessed flag.
// - Ports 26/27 reach exactly the same configuration registers as 22/23.
// - Every write to RTC index port 70 with byte lane 0 enabled is captured and read at 96h.
// - Level CPU holds SMM level across whole cycles; strobe CPU strobes each cycle.
// - Level CPUs keep cache-enable handling in SMM; optional flush on entry.
// - Strobe CPUs leave mask, cache-enable and flush untouched by SMM.
// - With write-back/through pin in use, write-protected areas report write-through.
// - Write-protected BIOS: either non-cacheable or snoop strobe on CPU writes.
// - Optional cache line protect output marks write-protected lines.
// - With flush enabled, flush output goes low for 4 clocks from the clock after SMM level falls.
// - Cycles to segments D-F select the SMM or user shadow enables from SMM indication; segment C always uses user enables.
package smm_pkg;

    // I/O ports, word index on the bus
    localparam logic [7:0] PORT_IDX_PRI = 8'h22;
    localparam logic [7:0] PORT_DAT_PRI = 8'h23;
    localparam logic [7:0] PORT_IDX_ALT = 8'h26;
    localparam logic [7:0] PORT_DAT_ALT = 8'h27;
    localparam logic [7:0] PORT_RTC_IDX = 8'h70;

    // Configuration indexes
    localparam logic [7:0] CFG_SHADOW_CACHE = 8'h18;
    localparam logic [7:0] CFG_USR_RD = 8'h19;
    localparam logic [7:0] CFG_USR_WR = 8'h1A;
    localparam logic [7:0] CFG_SMM_SHADOW = 8'h1C;
    localparam logic [7:0] CFG_SMM_CTRL = 8'h94;
    localparam logic [7:0] CFG_RTC_SHADOW = 8'h96;
    localparam logic [7:0] CFG_CPU_OPT = 8'h97;

    // Field positions
    localparam int L2_NC_BIT = 3;
    localparam int SHADOW_L1_NC_BIT = 2;
    localparam int SMM_L1_NC_BIT = 3;
    localparam int A20_FORCE_BIT = 2;
    localparam int OPT_STROBE_CPU = 0;
    localparam int OPT_FLUSH_EN = 1;
    localparam int OPT_WBWT_PIN = 2;
    localparam int OPT_WP_SNOOP = 3;
    localparam int OPT_PROT_PIN = 4;

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RTC_IDX_RESET = 8'h00;

    // Shadow region 0A0000h-0FFFFFh as address bits 31:16
    localparam logic [15:0] SHADOW_LO = 16'h000A;
    localparam logic [15:0] SHADOW_HI = 16'h000F;
    localparam logic [3:0] SEG_C = 4'hC;
    localparam logic [3:0] SEG_D = 4'hD;
    localparam logic [3:0] SEG_E = 4'hE;
    localparam logic [3:0] SEG_F = 4'hF;

    // Flush pulse length in clocks
    localparam int FLUSH_CLOCKS = 4;
    localparam int FLUSH_CW = 3;

    typedef struct packed {
        logic valid;
        logic set_gate;
    } smm_link_code_s;

    typedef struct packed {
        logic in_shadow;
        logic rd_en;
        logic wr_en;
    } smm_shadow_s;

endpackage : smm_pkg

//--- hdl/smm_support.sv
// Our own choices: register access over Wishbone and the register addresses.
module smm_support (
    input wire logic ref_clk,
    input wire logic arst_n,
    // Wishbone slave, I/O port number in adr[9:2]
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU side
    input wire logic smm_active_n,
    input wire logic smm_cycle_strobe_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic [31:14] cpu_addr,
    input wire logic cpu_write,
    input wire logic kbd_addr20_gate,
    input wire logic emu_addr20_gate,
    output logic cache_enable_n,
    output logic l2_cacheable,
    output logic writeback_or_through_sel,
    output logic cache_line_protect,
    output logic external_snoop_strobe_n_out,
    output logic external_snoop_strobe_n_oe,
    output logic cache_flush_n,
    output logic shadow_rd_en,
    output logic shadow_wr_en,
    output logic smm_now,
    // Link to companion chip
    output logic addr20_gate,
    output smm_pkg::smm_link_code_s link_code
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration storage

    logic [7:0] cfg_shadow_cache;
    logic [7:0] cfg_usr_rd;
    logic [7:0] cfg_usr_wr;
    logic [7:0] cfg_smm_shadow;
    logic [7:0] cfg_smm_ctrl;
    logic [7:0] cfg_cpu_opt;
    logic [7:0] rtc_idx_shadow;
    logic [7:0] idx_pri;
    logic [7:0] idx_alt;
    logic acc_pri;
    logic acc_alt;

    function automatic logic [7:0] cfg_read(input logic [7:0] idx);
        case (idx)
            smm_pkg::CFG_SHADOW_CACHE: cfg_read = cfg_shadow_cache;
            smm_pkg::CFG_USR_RD: cfg_read = cfg_usr_rd;
            smm_pkg::CFG_USR_WR: cfg_read = cfg_usr_wr;
            smm_pkg::CFG_SMM_SHADOW: cfg_read = cfg_smm_shadow;
            smm_pkg::CFG_SMM_CTRL: cfg_read = cfg_smm_ctrl;
            smm_pkg::CFG_RTC_SHADOW: cfg_read = rtc_idx_shadow;
            smm_pkg::CFG_CPU_OPT: cfg_read = cfg_cpu_opt;
            default: cfg_read = 8'h00;
        endcase
    endfunction : cfg_read

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    logic [7:0] port;
    logic req;
    logic wr_take;
    logic rd_take;
    logic byte0;
    logic [7:0] wdat;
    logic cfg_wr;
    logic [7:0] cfg_wr_idx;
    logic [7:0] rdat;

    assign port = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i;
    assign byte0 = wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];
    // Effects land on the edge where the master samples ack
    assign wr_take = req && wb_ack_o && wb_we_i && byte0;
    assign rd_take = req && wb_ack_o && !wb_we_i;

    // Both windows feed the same register set
    always_comb begin
        cfg_wr = 1'b0;
        cfg_wr_idx = idx_pri;
        if (wr_take && port == smm_pkg::PORT_DAT_PRI && acc_pri) begin
            cfg_wr = 1'b1;
        end else if (wr_take && port == smm_pkg::PORT_DAT_ALT && acc_alt) begin
            cfg_wr = 1'b1;
            cfg_wr_idx = idx_alt;
        end
    end

    always_comb begin
        case (port)
            smm_pkg::PORT_IDX_PRI: rdat = idx_pri;
            smm_pkg::PORT_DAT_PRI: rdat = acc_pri ? cfg_read(idx_pri) : 8'h00;
            smm_pkg::PORT_IDX_ALT: rdat = idx_alt;
            smm_pkg::PORT_DAT_ALT: rdat = acc_alt ? cfg_read(idx_alt) : 8'h00;
            default: rdat = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= {24'h00_0000, rdat};
            end
        end
    end

    // Window indexes and accessed flags, one set per window
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_pri <= smm_pkg::CFG_RESET;
            acc_pri <= 1'b0;
        end else if (wr_take && port == smm_pkg::PORT_IDX_PRI) begin
            idx_pri <= wdat;
            acc_pri <= 1'b1;
        end else if ((wr_take || rd_take) && port == smm_pkg::PORT_DAT_PRI) begin
            acc_pri <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_alt <= smm_pkg::CFG_RESET;
            acc_alt <= 1'b0;
        end else if (wr_take && port == smm_pkg::PORT_IDX_ALT) begin
            idx_alt <= wdat;
            acc_alt <= 1'b1;
        end else if ((wr_take || rd_take) && port == smm_pkg::PORT_DAT_ALT) begin
            acc_alt <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_idx_shadow <= smm_pkg::RTC_IDX_RESET;
        end else if (wr_take && port == smm_pkg::PORT_RTC_IDX) begin
            rtc_idx_shadow <= wdat;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_shadow_cache <= smm_pkg::CFG_RESET;
            cfg_usr_rd <= smm_pkg::CFG_RESET;
            cfg_usr_wr <= smm_pkg::CFG_RESET;
            cfg_smm_shadow <= smm_pkg::CFG_RESET;
            cfg_smm_ctrl <= smm_pkg::CFG_RESET;
            cfg_cpu_opt <= smm_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            case (cfg_wr_idx)
                smm_pkg::CFG_SHADOW_CACHE: cfg_shadow_cache <= wdat;
                smm_pkg::CFG_USR_RD: cfg_usr_rd <= wdat;
                smm_pkg::CFG_USR_WR: cfg_usr_wr <= wdat;
                smm_pkg::CFG_SMM_SHADOW: cfg_smm_shadow <= wdat;
                smm_pkg::CFG_SMM_CTRL: cfg_smm_ctrl <= wdat;
                smm_pkg::CFG_CPU_OPT: cfg_cpu_opt <= wdat;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SMM indication

    logic strobe_cpu;
    logic level_smm;
    logic level_smm_q;
    logic cyc_start;
    logic smm_cyc;
    logic next_smm_now;

    assign strobe_cpu = cfg_cpu_opt[smm_pkg::OPT_STROBE_CPU];
    assign level_smm = !strobe_cpu && !smm_active_n;
    assign cyc_start = !cpu_addr_strobe_n || !smm_cycle_strobe_n;
    // Strobe CPUs mark SMM per cycle, so hold the mark until the next start
    assign smm_cyc = strobe_cpu ? !smm_cycle_strobe_n : level_smm;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_smm_q <= 1'b0;
        end else begin
            level_smm_q <= level_smm;
        end
    end

    always_comb begin
        next_smm_now = smm_now;
        if (!strobe_cpu) begin
            next_smm_now = level_smm;
        end else if (cyc_start) begin
            next_smm_now = smm_cyc;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            smm_now <= 1'b0;
        end else begin
            smm_now <= next_smm_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shadow decode

    function automatic smm_pkg::smm_shadow_s shadow_sel(input logic [31:14] a,
                                                       input logic smm);
        smm_pkg::smm_shadow_s s;
        s.in_shadow = a[31:16] >= smm_pkg::SHADOW_LO && a[31:16] <= smm_pkg::SHADOW_HI;
        s.rd_en = 1'b0;
        s.wr_en = 1'b0;
        if (s.in_shadow) begin
            case (a[19:16])
                smm_pkg::SEG_C: begin
                    s.rd_en = cfg_usr_rd[a[15:14]];
                    s.wr_en = cfg_usr_wr[a[15:14]];
                end
                smm_pkg::SEG_D: begin
                    s.rd_en = smm ? cfg_smm_shadow[0] : cfg_usr_rd[4];
                    s.wr_en = smm ? cfg_smm_shadow[4] : cfg_usr_wr[4];
                end
                smm_pkg::SEG_E: begin
                    s.rd_en = smm ? cfg_smm_shadow[1] : cfg_usr_rd[5];
                    s.wr_en = smm ? cfg_smm_shadow[5] : cfg_usr_wr[5];
                end
                smm_pkg::SEG_F: begin
                    s.rd_en = smm ? cfg_smm_shadow[2] : cfg_usr_rd[6];
                    s.wr_en = smm ? cfg_smm_shadow[6] : cfg_usr_wr[6];
                end
                default: ;
            endcase
        end
        return s;
    endfunction : shadow_sel

    smm_pkg::smm_shadow_s sh;
    logic wp_area;
    logic l1_nc;
    logic wp_snoop;

    assign sh = shadow_sel(cpu_addr, next_smm_now);
    // Read from shadow while writes go elsewhere
    assign wp_area = sh.in_shadow && sh.rd_en && !sh.wr_en;
    assign wp_snoop = cfg_cpu_opt[smm_pkg::OPT_WP_SNOOP];

    always_comb begin
        l1_nc = 1'b0;
        if (sh.in_shadow && cfg_shadow_cache[smm_pkg::SHADOW_L1_NC_BIT]) begin
            l1_nc = 1'b1;
        end
        // Strobe CPUs keep cache-enable as in user mode
        if (!strobe_cpu && next_smm_now && sh.in_shadow
            && cfg_smm_ctrl[smm_pkg::SMM_L1_NC_BIT]) begin
            l1_nc = 1'b1;
        end
        if (wp_area && !wp_snoop) begin
            l1_nc = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_enable_n <= 1'b1;
            l2_cacheable <= 1'b0;
            writeback_or_through_sel <= 1'b1;
            cache_line_protect <= 1'b0;
            shadow_rd_en <= 1'b0;
            shadow_wr_en <= 1'b0;
        end else if (cyc_start) begin
            cache_enable_n <= l1_nc;
            l2_cacheable <= !(sh.in_shadow && cfg_shadow_cache[smm_pkg::L2_NC_BIT]);
            writeback_or_through_sel <= !(cfg_cpu_opt[smm_pkg::OPT_WBWT_PIN] && wp_area);
            cache_line_protect <= cfg_cpu_opt[smm_pkg::OPT_PROT_PIN] && wp_area;
            shadow_rd_en <= sh.rd_en;
            shadow_wr_en <= sh.wr_en;
        end
    end

    // Snoop strobe for CPU writes into write-protected BIOS
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            external_snoop_strobe_n_out <= 1'b1;
            external_snoop_strobe_n_oe <= 1'b0;
        end else begin
            external_snoop_strobe_n_out <= !(cyc_start && cpu_write && wp_area && wp_snoop);
            external_snoop_strobe_n_oe <= cyc_start && cpu_write && wp_area && wp_snoop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flush on SMM entry

    logic [smm_pkg::FLUSH_CW-1:0] flush_cnt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_cnt <= '0;
        end else if (level_smm && !level_smm_q && cfg_cpu_opt[smm_pkg::OPT_FLUSH_EN]) begin
            flush_cnt <= smm_pkg::FLUSH_CW'(smm_pkg::FLUSH_CLOCKS);
        end else if (flush_cnt != '0) begin
            flush_cnt <= flush_cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_flush_n <= 1'b1;
        end else begin
            cache_flush_n <= !(level_smm && !level_smm_q && cfg_cpu_opt[smm_pkg::OPT_FLUSH_EN])
                && flush_cnt <= smm_pkg::FLUSH_CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address-20 gate forcing

    logic force_en;
    logic base_gate;

    // Level CPUs only
    assign force_en = cfg_smm_ctrl[smm_pkg::A20_FORCE_BIT] && !strobe_cpu;
    assign base_gate = kbd_addr20_gate || emu_addr20_gate;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr20_gate <= 1'b0;
        end else begin
            addr20_gate <= base_gate || (force_en && level_smm);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_code <= '0;
        end else begin
            link_code.valid <= force_en && !base_gate
                && (level_smm != level_smm_q);
            link_code.set_gate <= level_smm;
        end
    end

endmodule : smm_support

//--- test/smm_support_properties.sv
module smm_support_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic smm_active_n,
    input wire logic smm_cycle_strobe_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic cpu_write,
    input wire logic kbd_addr20_gate,
    input wire logic emu_addr20_gate,
    input wire logic cache_flush_n,
    input wire logic external_snoop_strobe_n_out,
    input wire logic external_snoop_strobe_n_oe,
    input wire logic smm_now,
    input wire logic addr20_gate,
    input wire smm_pkg::smm_link_code_s link_code
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence flush_hold;
        !cache_flush_n [*4] ##1 cache_flush_n;
    endsequence
    // Gate level and link code are launched on the same edge
    sequence gate_moves;
        (addr20_gate == link_code.set_gate) && ($past(addr20_gate) != link_code.set_gate);
    endsequence

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    flush_len_a: assert property ($fell(cache_flush_n) |-> flush_hold)
        else $error("flush pulse not four clocks");
    flush_cause_a: assert property ($fell(cache_flush_n) |->
        !$past(smm_active_n) && $past(smm_active_n, 2))
        else $error("flush without smm entry");
    gate_or_a: assert property ((kbd_addr20_gate || emu_addr20_gate) |=> addr20_gate)
        else $error("gate low with keyboard gate high");
    gate_code_a: assert property (link_code.valid |-> gate_moves)
        else $error("link code does not match gate change");
    code_pulse_a: assert property (link_code.valid |=> !link_code.valid)
        else $error("link code longer than one cycle");
    smm_strobe_a: assert property (!smm_cycle_strobe_n |=> smm_now)
        else $error("smm strobe not flagged");
    smm_user_a: assert property (!cpu_addr_strobe_n && smm_active_n && smm_cycle_strobe_n
        |=> !smm_now)
        else $error("user cycle flagged as smm");
    snoop_pulse_a: assert property (external_snoop_strobe_n_oe |->
        !external_snoop_strobe_n_out && $past(!cpu_addr_strobe_n && cpu_write)
        ##1 !external_snoop_strobe_n_oe)
        else $error("bad snoop strobe");
endmodule : smm_support_checker

bind smm_support smm_support_checker chk (.ref_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .smm_active_n, .smm_cycle_strobe_n, .cpu_addr_strobe_n, .cpu_write,
    .kbd_addr20_gate, .emu_addr20_gate, .cache_flush_n, .external_snoop_strobe_n_out,
    .external_snoop_strobe_n_oe, .smm_now, .addr20_gate, .link_code);

//--- test/smm_cpu_model.sv
module smm_cpu_model (
    input wire logic ref_clk,
    input wire logic strobe_mode,
    output logic smm_active_n,
    output logic smm_cycle_strobe_n,
    output logic cpu_addr_strobe_n,
    output logic [31:14] cpu_addr,
    output logic cpu_write
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        smm_active_n = 1'h1;
        smm_cycle_strobe_n = 1'h1;
        cpu_addr_strobe_n = 1'h1;
        cpu_addr = 18'h0;
        cpu_write = 1'h0;
    end
    // Level moves only between cycles, with margin
    task automatic level(input logic on);
        repeat (4) @(posedge ref_clk);
        smm_active_n <= !on;
        repeat (4) @(posedge ref_clk);
    endtask : level
    // Address lines show junk once the cycle is taken
    task automatic cycle(input logic [31:0] a, input logic wr, input logic smm);
        @(posedge ref_clk);
        cpu_addr <= a[31:14];
        cpu_write <= wr;
        if (strobe_mode && smm) begin
            smm_cycle_strobe_n <= 1'h0;
        end else begin
            cpu_addr_strobe_n <= 1'h0;
        end
        @(posedge ref_clk);
        smm_cycle_strobe_n <= 1'h1;
        cpu_addr_strobe_n <= 1'h1;
        cpu_addr <= ~a[31:14];
        cpu_write <= !wr;
    endtask : cycle
endmodule : smm_cpu_model

//--- test/smm_support_logic_tb.sv
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module smm_support_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, kbd = 0, emu = 0, strobe = 0;
    logic [9:0] adr = 0;
    logic [3:0] sel = 0, bsel = 4'h1;
    logic [31:0] dat = 0, wb_dat_o;
    logic wb_ack_o, cache_enable_n, l2_cacheable, writeback_or_through_sel, cache_line_protect;
    logic external_snoop_strobe_n_out, external_snoop_strobe_n_oe, cache_flush_n, smm_now;
    logic shadow_rd_en, shadow_wr_en, addr20_gate, smm_active_n, smm_cycle_strobe_n;
    logic cpu_addr_strobe_n, cpu_write;
    logic [31:14] cpu_addr;
    smm_pkg::smm_link_code_s link_code;
    int mismatches = 0, n_tests = 0, n_set = 0, n_clr = 0, n_flush = 0, n_snoop = 0;
    int seed = 75319;
    logic [7:0] q, v, w;
    always #2.5 ref_clk = !ref_clk;
    smm_cpu_model cpu (.ref_clk, .strobe_mode(strobe), .smm_active_n, .smm_cycle_strobe_n,
        .cpu_addr_strobe_n, .cpu_addr, .cpu_write);
    smm_support dut (.ref_clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .smm_active_n,
        .smm_cycle_strobe_n, .cpu_addr_strobe_n, .cpu_addr, .cpu_write,
        .kbd_addr20_gate(kbd), .emu_addr20_gate(emu), .cache_enable_n, .l2_cacheable,
        .writeback_or_through_sel, .cache_line_protect, .external_snoop_strobe_n_out,
        .external_snoop_strobe_n_oe, .cache_flush_n, .shadow_rd_en, .shadow_wr_en, .smm_now,
        .addr20_gate, .link_code);
    always @(posedge ref_clk) begin
        if (link_code.valid && link_code.set_gate) n_set++;
        if (link_code.valid && !link_code.set_gate) n_clr++;
        if (!cache_flush_n) n_flush++;
        if (external_snoop_strobe_n_oe && !external_snoop_strobe_n_out) n_snoop++;
    end
    function automatic logic exp_codes(input logic f, input logic g, input logic s);
        return f & !g & !s;
    endfunction : exp_codes
    task automatic wb(input logic w_en, input logic [7:0] port, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge ref_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w_en;
        sel <= bsel;
        adr <= {port, 2'h0};
        dat <= ($random(seed) & 32'hFFFFFF00) | {24'h0, d};
        do begin
            @(posedge ref_clk);
            t++;
        end while (wb_ack_o !== 1'h1 && t < 20);
        if (t >= 20) mismatches++;
        q = wb_dat_o[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    task automatic cfg(input logic alt, input logic w_en, input logic [7:0] i, input logic [7:0] d);
        wb(1'h1, alt ? 8'h26 : 8'h22, i);
        wb(w_en, alt ? 8'h27 : 8'h23, d);
    endtask : cfg
    task report_and_stop;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        #1 `CHK("flush_idle", 1'h1, cache_flush_n)
        cfg(1, 0, 8'h94, 8'h0);
        `CHK("cfg94_reset", 8'h00, q)
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            cfg(0, 1, 8'h19, v);
            wb(1, 8'h22, 8'h1A);
            cfg(1, 1, 8'h1A, w);
            wb(1, 8'h23, ~v);
            cfg(1, 0, 8'h19, 8'h0);
            `CHK("alt_view", v, q)
            cfg(0, 0, 8'h1A, 8'h0);
            `CHK("pri_index_kept", ~v, q)
            wb(0, 8'h27, 8'h0);
            `CHK("data_no_index", 8'h00, q)
            wb(1, 8'h70, w);
            cfg(1, 0, 8'h96, 8'h0);
            `CHK("rtc_shadow", w, q)
            wb(1, 8'h70, q);
        end
        wb(0, 8'h30, 8'h0);
        `CHK("unmapped", 8'h00, q)
        bsel = 4'hE;
        cfg(1, 1, 8'h19, 8'h5A);
        bsel = 4'h1;
        cfg(1, 0, 8'h19, 8'h0);
        `CHK("no_lane", v, q)
        ////////////////////////////////////////////////////////////////////////////////
        cfg(1, 1, 8'h18, 8'h08);
        cfg(1, 1, 8'h19, 8'h40);
        cfg(1, 1, 8'h1A, 8'h40);
        cfg(1, 1, 8'h1C, 8'h22);
        for (int j = 0; j < 4; j++) begin
            cfg(1, 1, 8'h94, j[0] ? 8'h08 : 8'h00);
            cpu.level(j[1]);
            cpu.cycle(32'h000E0000 | ($random(seed) & 32'hFFFC), 0, j[1]);
            #1 if (j[1]) `CHK("smm_l1", j[0], cache_enable_n)
            `CHK("smm_l2", 1'h0, l2_cacheable)
            `CHK("rd_sel", j[1], shadow_rd_en)
            `CHK("wr_sel", j[1], shadow_wr_en)
            cpu.level(0);
            cpu.cycle(32'h000F0000 | ($random(seed) & 32'hFFFC), 0, 0);
            #1 `CHK("bios_l1", 1'h0, cache_enable_n)
            `CHK("bios_l2", 1'h0, l2_cacheable)
            cpu.cycle(32'h00200000 | ($random(seed) & 32'hFFFFC), 0, 0);
            #1 `CHK("dram_l2", 1'h1, l2_cacheable)
        end
        cfg(1, 1, 8'h1A, 8'h00);
        for (int k = 0; k < 2; k++) begin
            cfg(1, 1, 8'h97, k ? 8'h1C : 8'h04);
            n_snoop = 0;
            cpu.cycle(32'h000F0000 | ($random(seed) & 32'hFFFC), 1, 0);
            @(posedge ref_clk);
            #1 `CHK("snoop", k, n_snoop)
            `CHK("wp_through", 1'h0, writeback_or_through_sel)
            `CHK("line_protect", k[0], cache_line_protect)
            `CHK("wp_uncached", !k[0], cache_enable_n)
        end
        cfg(1, 1, 8'h18, 8'h0C);
        cpu.cycle(32'h000C0000 | ($random(seed) & 32'hFFFC), 0, 0);
        #1 `CHK("shadow_l1_nc", 1'h1, cache_enable_n)
        `CHK("shadow_l2_nc", 1'h0, l2_cacheable)
        ////////////////////////////////////////////////////////////////////////////////
        for (int i = 0; i < 8; i++) begin
            strobe = i[2];
            cfg(1, 1, 8'h97, {6'h0, 1'h1, i[2]});
            cfg(1, 1, 8'h94, {5'h0, i[0], 2'h0});
            @(posedge ref_clk);
            kbd <= i[1] & i[0];
            emu <= i[1] & !i[0];
            n_set = 0;
            n_clr = 0;
            n_flush = 0;
            cpu.level(1);
            if (i[2]) cpu.cycle(32'h000E0000, 0, 1);
            #1 `CHK("smm_flag", 1'h1, smm_now)
            `CHK("gate_smm", i[1] | (i[0] & !i[2]), addr20_gate)
            cpu.level(0);
            #1 `CHK("set_codes", exp_codes(i[0], i[1], i[2]), n_set)
            `CHK("clr_codes", exp_codes(i[0], i[1], i[2]), n_clr)
            `CHK("flush_count", i[2] ? 0 : 4, n_flush)
            `CHK("gate_back", i[1], addr20_gate)
            @(posedge ref_clk);
            kbd <= 1'h0;
            emu <= 1'h0;
        end
        report_and_stop;
    end
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
endmodule : smm_support_logic_tb
